// File: add_carry_and_literal_exec.sv
// Execution unit for add-with-carry-to-file and AND-literal instructions.
//
// Summary of operation
// - Add accumulator, carry, file byte; set five flags.
// - Destination bit selects accumulator or file writeback.
// - Access bit picks access bank or bank register.
// - Extended set, access, address<=95: indexed literal offset.
// - AND literal into accumulator; update N, Z only.
`timescale 1ns/100ps
`include "exec_regs.svh"
module add_carry_and_literal_exec (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic is_add_i,
  input wire logic is_and_i,
  input wire logic [7:0] file_addr_i,
  input wire logic dest_i,
  input wire logic access_i,
  input wire logic [7:0] literal_i,
  input wire logic ext_set_i,
  input wire logic [3:0] bank_wr_data_i,
  input wire logic bank_wr_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [11:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] accum_o,
  output logic [4:0] flags_o,
  output logic [3:0] bank_o,
  output logic busy_o,
  output logic done_o
);
  // Decoded instruction, held for the length of one instruction cycle.
  exec_pkg::phase_e phase;
  exec_pkg::op_e op;
  logic [7:0] lit;
  logic dest;
  logic [7:0] operand;
  logic [7:0] result;
  logic [4:0] next_flags;
  logic [11:0] next_addr;
  logic [7:0] sum;
  logic c_add;
  logic digit_carry_add;
  logic overflow_add;
  logic z_add;
  logic n_add;
  logic [7:0] and_res;
  logic take;
  logic take_add;

  // The carry flag is the adder's carry in, so no extra state is kept.
  add_flags u_add (
    .a_i(accum_o),
    .b_i(operand),
    .cin_i(flags_o[`FLAG_C]),
    .sum_o(sum),
    .c_o(c_add),
    .digit_carry_o(digit_carry_add),
    .overflow_o(overflow_add),
    .z_o(z_add),
    .n_o(n_add)
  );

  // An instruction is taken only from the idle decode phase. A start while
  // busy, or one with neither opcode bit set, is dropped without effect.
  assign take = (phase == exec_pkg::ph_decode) && start_i && !busy_o
                && (is_add_i || is_and_i);
  // Add wins when both opcode bits arrive together.
  assign take_add = take && is_add_i;

  // Operand address: indexed offset first, then access bank, then banked.
  // The indexed window covers only the low end of the access bank, so an
  // address above the limit falls back to the plain access-bank split.
  // The index base is not range checked; a sum past the top wraps round.
  always_comb begin
    if (ext_set_i && !access_i && file_addr_i <= `ILO_LIMIT) begin
      next_addr = index_base_i + {4'h0, file_addr_i};
    end else if (!access_i) begin
      if (file_addr_i < `ACCESS_SPLIT) begin
        next_addr = {4'h0, file_addr_i};
      end else begin
        next_addr = {`ACCESS_HIGH_BANK, file_addr_i};
      end
    end else begin
      next_addr = {bank_o, file_addr_i};
    end
  end

  // AND result and flags of whichever instruction is in process.
  always_comb begin
    and_res = accum_o & lit;
    result = sum;
    next_flags = flags_o;
    case (op)
      exec_pkg::op_add_accum_carry_file: begin
        result = sum;
        next_flags[`FLAG_C] = c_add;
        next_flags[`FLAG_DIGIT_CARRY] = digit_carry_add;
        next_flags[`FLAG_Z] = z_add;
        next_flags[`FLAG_OVERFLOW] = overflow_add;
        next_flags[`FLAG_N] = n_add;
      end
      exec_pkg::op_and_literal_accum: begin
        // Only N and Z follow the AND; carry, digit carry and overflow
        // keep what the last add left, as software may still test them.
        result = and_res;
        next_flags[`FLAG_Z] = (and_res == 8'h00);
        next_flags[`FLAG_N] = and_res[7];
      end
      default: begin
        result = sum;
      end
    endcase
  end

  // Four-phase sequencer; a new start is ignored while busy.
  // Timing is counted in clock edges from the edge that takes the start.
  // At edge 0 the fields latch and an add issues its operand read.
  // At edge 1 the file byte is captured from the data memory.
  // At edge 2 the flags, the accumulator or the file write are committed.
  // At edge 3 done pulses and the block returns to the decode phase.
  // Spending a clock on each phase keeps every output registered, at the
  // cost of four clocks per instruction.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= exec_pkg::ph_decode;
      op <= exec_pkg::op_none;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      lit <= 8'h00;
      dest <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (phase)
        exec_pkg::ph_decode: begin
          if (take) begin
            busy_o <= 1'b1;
            phase <= exec_pkg::ph_read;
            lit <= literal_i;
            dest <= dest_i;
            op <= is_add_i ? exec_pkg::op_add_accum_carry_file
                           : exec_pkg::op_and_literal_accum;
          end
        end
        exec_pkg::ph_read: begin
          phase <= exec_pkg::ph_process;
        end
        exec_pkg::ph_process: begin
          phase <= exec_pkg::ph_write;
        end
        exec_pkg::ph_write: begin
          phase <= exec_pkg::ph_decode;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          op <= exec_pkg::op_none;
        end
        default: begin
          phase <= exec_pkg::ph_decode;
        end
      endcase
    end
  end

  // Memory side: address latched at decode, read strobe in read phase.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_o <= 12'h000;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      operand <= 8'h00;
    end else begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      // The address stands until the next add, so a file write-back reuses
      // it and no second address register is needed.
      if (take_add) begin
        mem_addr_o <= next_addr;
        mem_rd_o <= 1'b1;
      end
      // Data arrives in the same cycle as the strobe, at the read phase.
      // The byte is taken for either destination, as the sum needs it.
      if (phase == exec_pkg::ph_read
          && op == exec_pkg::op_add_accum_carry_file) begin
        operand <= mem_rdata_i;
      end
      if (phase == exec_pkg::ph_process
          && op == exec_pkg::op_add_accum_carry_file && dest) begin
        mem_wr_o <= 1'b1;
        mem_wdata_o <= result;
      end
    end
  end

  // Accumulator and flags commit on the edge that ends the process phase.
  // A file destination leaves the accumulator alone, but the flags still
  // follow the sum.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accum_o <= `ACCUM_RST;
      flags_o <= `FLAGS_RST;
    end else if (phase == exec_pkg::ph_process) begin
      flags_o <= next_flags;
      if (op == exec_pkg::op_and_literal_accum || !dest) begin
        accum_o <= result;
      end
    end
  end

  // Bank select register, loaded by the core; banked addressing reads it.
  // A load during an instruction is harmless, as the operand address is
  // latched at decode and not looked at again.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_o <= `BANK_RST;
    end else if (bank_wr_i) begin
      bank_o <= bank_wr_data_i;
    end
  end
endmodule : add_carry_and_literal_exec

// File: add_flags.sv
// Adder that forms the add-with-carry sum and its arithmetic flags.
`timescale 1ns/100ps
module add_flags (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  output logic [7:0] sum_o,
  output logic c_o,
  output logic digit_carry_o,
  output logic overflow_o,
  output logic z_o,
  output logic n_o
);
  logic [4:0] low;
  logic [8:0] full;

  // Low nibble gives the digit carry; full width gives carry and overflow.
  always_comb begin
    low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    sum_o = full[7:0];
    c_o = full[8];
    digit_carry_o = low[4];
    overflow_o = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
    z_o = (full[7:0] == 8'h00);
    n_o = full[7];
  end
endmodule : add_flags

// File: data_mem.sv
// Behavioural banked data memory on the block's far side.
`timescale 1ns/100ps
module data_mem (
  input wire logic sys_clk_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [4096];
  // Seeded from the address so a wrong address reads a wrong byte.
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ i[11:4];
  // Read data follow the address, valid in the same cycle as the strobe.
  assign mem_rdata_o = mem[mem_addr_i];
  always @(posedge sys_clk_i) if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
endmodule : data_mem

// File: exec_checker.sv
// Port checker for the add-with-carry and AND-literal block.
`timescale 1ns/100ps
module exec_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic is_add_i,
  input wire logic is_and_i,
  input wire logic dest_i,
  input wire logic [7:0] literal_i,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] accum_o,
  input wire logic [4:0] flags_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Taken requests; add wins when both opcode bits are set.
  wire ad = start_i && !busy_o && is_add_i;
  wire an = start_i && !busy_o && is_and_i && !is_add_i;
  property p_run; ad || an |=> busy_o [*3] ##1 done_o; endproperty
  a_run: assert property (p_run) else $error("bad cycle");
  property p_rd; ad |=> mem_rd_o ##1 !mem_rd_o; endproperty
  a_rd: assert property (p_rd) else $error("no read");
  property p_wr; ad && dest_i |-> ##3 mem_wr_o; endproperty
  a_wr: assert property (p_wr) else $error("no write");
  property p_acc; ad && !dest_i |-> ##3 !mem_wr_o; endproperty
  a_acc: assert property (p_acc) else $error("stray write");
  property p_and;
    an |-> ##3 accum_o == ($past(accum_o, 3) & $past(literal_i, 3));
  endproperty
  a_and: assert property (p_and) else $error("bad and");
  property p_keep; an |-> ##3 $stable({flags_o[3], flags_o[1:0]}); endproperty
  a_keep: assert property (p_keep) else $error("flag hit");
  property p_mem; an |=> !mem_rd_o ##2 !mem_wr_o; endproperty
  a_mem: assert property (p_mem) else $error("file touched");
  // N and Z always follow a new accumulator value.
  property p_nz; $changed(accum_o) |->
    flags_o[4] == accum_o[7] && flags_o[2] == (accum_o == 8'h00); endproperty
  a_nz: assert property (p_nz) else $error("bad nz");
endmodule : exec_checker

// File: exec_pkg.sv
// Types shared by the execution block.
package exec_pkg;
  typedef enum logic [1:0] {
    op_none,
    op_add_accum_carry_file,
    op_and_literal_accum
  } op_e;
  typedef enum logic [1:0] {
    ph_decode,
    ph_read,
    ph_process,
    ph_write
  } phase_e;
endpackage : exec_pkg

// File: exec_regs.svh
// Constants for the add-with-carry and AND-literal execution block.
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
`define ACCUM_RST 8'h00
`define BANK_RST 4'h0
`define FLAGS_RST 5'h00
`define FLAG_C 0
`define FLAG_DIGIT_CARRY 1
`define FLAG_Z 2
`define FLAG_OVERFLOW 3
`define FLAG_N 4
`define ILO_LIMIT 8'h5f
`define ACCESS_HIGH_BANK 4'hf
`define ACCESS_SPLIT 8'h80
`define Q_LAST 2'h3
`endif

// File: tb.sv
// Self-checking bench for the execution block.
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 0, rst_n_i = 0, start_i = 0, is_add_i = 0, is_and_i = 0;
  logic dest_i = 0, access_i = 0, ext_set_i = 0, bank_wr_i = 0, c;
  logic mem_rd_o, mem_wr_o, busy_o, done_o;
  logic [7:0] file_addr_i = 0, literal_i = 0, mem_rdata_i, mem_wdata_o;
  logic [7:0] accum_o, acc = 0, b, r, wd = 0, ew = 0;
  logic [3:0] bank_wr_data_i = 0, bank_o, bk = 0;
  logic [11:0] index_base_i = 0, mem_addr_o, ea, la = 0;
  logic [4:0] flags_o, fl = 0;
  logic [36:0] q[$];
  int failures = 0, checks = 0, seed = 32'h5ebfafcb, op, rnd;
  always #2.5 sys_clk_i = ~sys_clk_i;
  add_carry_and_literal_exec i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .is_add_i(is_add_i), .is_and_i(is_and_i), .file_addr_i(file_addr_i),
    .dest_i(dest_i), .access_i(access_i), .literal_i(literal_i),
    .ext_set_i(ext_set_i), .bank_wr_data_i(bank_wr_data_i),
    .bank_wr_i(bank_wr_i), .index_base_i(index_base_i),
    .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .accum_o(accum_o), .flags_o(flags_o), .bank_o(bank_o),
    .busy_o(busy_o), .done_o(done_o));
  data_mem i_mem (.sys_clk_i, .mem_addr_i(mem_addr_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  task automatic chk(input logic [36:0] s, input logic [36:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Each done pulse retires the oldest expected result.
  always @(posedge sys_clk_i) begin
    if (mem_wr_o) wd = mem_wdata_o;
    if (done_o && q.size() == 0) begin
      chk(37'h0, 37'h1);
    end else if (done_o) begin
      chk({accum_o, flags_o, wd, mem_addr_o, bank_o}, q.pop_front());
    end
  end
  // Start is held a second cycle so a request while busy is refused.
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1;
    for (int i = 0; i < 400; i++) begin
      op = $random(seed);
      @(posedge sys_clk_i);
      bank_wr_i <= op[12];
      bank_wr_data_i <= op[11:8];
      if (op[12]) bk = op[11:8];
      @(posedge sys_clk_i);
      bank_wr_i <= 0;
      {is_and_i, is_add_i, dest_i, access_i, ext_set_i} <= op[4:0];
      rnd = $random(seed);
      file_addr_i <= rnd[15:8];
      literal_i <= rnd[7:0];
      index_base_i <= op[31:20];
      start_i <= 1;
      @(posedge sys_clk_i);
      if (access_i) begin
        ea = {bk, file_addr_i};
      end else if (ext_set_i && file_addr_i <= 8'h5f) begin
        ea = index_base_i + {4'h0, file_addr_i};
      end else begin
        ea = {file_addr_i[7] ? 4'hf : 4'h0, file_addr_i};
      end
      if (is_add_i) begin
        la = ea;
        b = i_mem.mem[ea];
        {c, r} = acc + b + fl[0];
        fl = {r[7], acc[7] == b[7] && r[7] != acc[7], r == 0,
          acc[3:0] + b[3:0] + fl[0] > 15, c};
        if (dest_i) ew = r;
        else acc = r;
      end else if (is_and_i) begin
        acc = acc & literal_i;
        fl[4] = acc[7];
        fl[2] = acc == 0;
      end
      if (is_add_i || is_and_i) q.push_back({acc, fl, ew, la, bk});
      @(posedge sys_clk_i);
      start_i <= 0;
      repeat (4) @(posedge sys_clk_i);
    end
    chk(37'(q.size()), 37'h0);
    results();
  end
endmodule : tb
bind add_carry_and_literal_exec exec_checker i_chk (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .start_i(start_i),
  .is_add_i(is_add_i),
  .is_and_i(is_and_i),
  .dest_i(dest_i),
  .literal_i(literal_i),
  .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o),
  .accum_o(accum_o),
  .flags_o(flags_o),
  .busy_o(busy_o),
  .done_o(done_o)
);
